// ---- hdl/adc_register_map.sv ----
/*
   Register map and serial port of a multichannel converter, with a 16-word result FIFO.
   Assumes serial pins are asynchronous to mclk_i (sclk well below mclk_i/4), and that the
   conversion stream, busy flag and setup buffer bits come from logic on mclk_i.
*/
// Overview of operation
// RULE1 - append status byte after each result when enabled
// RULE2 - status low bits name the result's channel
// RULE3 - drive boost bit raises data-out pin drive
// RULE4 - power switch bit turns the sink switch on
// RULE5 - temperature sensor picked via channel input selects
// RULE6 - temperature pick forces both input buffers on; the code forces them only while conv_busy_i is high
// RULE7 - command byte: write enable low, read bit, address
// RULE8 - status register read at address zero, reset 0x80
// RULE9 - converter mode register, reset 0xA000
// RULE10 - interface mode register, reset zero
// RULE11 - read-only checksum over monitored configuration registers
// RULE12 - 24-bit result register, MSB first
// RULE13 - pin configuration register, reset 0x0800
// RULE14 - read-only identity register
// RULE15 - channel zero map register, reset 0x8001
// RULE16 - check error set on mismatch, cleared by status read
// RULE17 - short word bit rounds results to 16 bits
// RULE18 - host reads the extra status byte
// RULE19 - read-only writes ignored, reserved bits read zero
module adc_register_map
   import adc_regs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic sclk_i,
   input wire logic cs_b_i,
   input wire logic din_i,
   input wire logic error_in_b_i,
   input wire logic conv_valid_i,
   input wire conv_word_s conv_word_i,
   input wire logic conv_busy_i,
   input wire logic [1:0] setup_ain_buf_i,
   output logic conv_ready_o,
   output logic dout_rdy_o,
   output logic dout_oe_o,
   output logic drive_boost_o,
   output logic power_switch_o,
   output logic [4:0] mux_pos_o,
   output logic [4:0] mux_neg_o,
   output logic [1:0] ain_buf_on_o,
   output mode_cfg_s mode_cfg_o
);
   logic [2:0] sclk_sync;
   logic [2:0] cs_sync;
   logic [1:0] din_sync;
   logic [1:0] err_sync;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;

   spi_state_e state;
   spi_state_e next_state;
   logic [2:0] bit_cnt;
   logic [2:0] next_bit_cnt;
   logic [2:0] byte_cnt;
   logic [2:0] next_byte_cnt;
   logic [2:0] nbytes;
   logic [2:0] next_nbytes;
   logic [6:0] shift_in;
   logic [6:0] next_shift_in;
   logic [31:0] shift_out;
   logic [31:0] next_shift_out;
   logic [5:0] addr;
   logic [5:0] next_addr;
   logic is_read;
   logic next_is_read;
   logic [23:0] wbuf;
   logic [23:0] next_wbuf;
   logic [7:0] lrc;
   logic [7:0] next_lrc;
   logic apply;
   logic next_apply;

   logic [15:0] conv_mode;
   logic [15:0] next_conv_mode;
   logic [15:0] if_mode;
   logic [15:0] next_if_mode;
   logic [15:0] pin_cfg;
   logic [15:0] next_pin_cfg;
   logic [15:0] ch0_map;
   logic [15:0] next_ch0_map;
   logic [23:0] checksum;
   logic [23:0] next_checksum;
   logic [23:0] ref_sum;
   logic [23:0] next_ref_sum;
   logic [23:0] result;
   logic [23:0] next_result;
   logic [3:0] channel;
   logic [3:0] next_channel;
   logic conv_err;
   logic next_conv_err;
   logic rdy_b;
   logic next_rdy_b;
   logic crc_err;
   logic next_crc_err;
   logic reg_err;
   logic next_reg_err;
   logic reg_check_q;
   logic dout;
   logic next_dout;
   logic oe;
   logic next_oe;
   logic [1:0] buf_on;
   logic [1:0] next_buf_on;

   logic [7:0] status;
   logic [7:0] byte_val;
   logic byte_done;
   logic crc_on;
   logic short_word;
   logic append;
   logic temp_pick;
   logic pop;
   logic [23:0] live_sum;
   conv_word_s fifo_word;
   logic fifo_valid;

   result_fifo #(
      .WIDTH($bits(conv_word_s)),
      .DEPTH(RESULT_FIFO_DEPTH)
   ) u_result_fifo (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(conv_valid_i),
      .in_ready_o(conv_ready_o),
      .in_data_i(conv_word_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_word)
   );

   // pins are asynchronous; edges are taken only from the second and third stages
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sclk_sync <= 3'b111;
         cs_sync <= 3'b111;
         din_sync <= 2'b00;
         err_sync <= 2'b11;
      end
      else
      begin
         sclk_sync <= {sclk_sync[1:0], sclk_i};
         cs_sync <= {cs_sync[1:0], cs_b_i};
         din_sync <= {din_sync[0], din_i};
         err_sync <= {err_sync[0], error_in_b_i};
      end
   end

   assign sclk_rise = sclk_sync[1] && !sclk_sync[2];
   assign sclk_fall = !sclk_sync[1] && sclk_sync[2];
   assign cs_fall = !cs_sync[1] && cs_sync[2];
   assign cs_rise = cs_sync[1] && !cs_sync[2];

   assign crc_on = (if_mode[IF_CRC_LO +: 2] != 2'b00);
   assign short_word = if_mode[IF_SHORT_WORD_BIT];
   assign append = if_mode[IF_STATUS_APPEND_BIT];
   assign status = {rdy_b, conv_err, crc_err, reg_err, channel}; // RULE8 RULE2
   assign byte_val = {shift_in, din_sync[1]};
   assign byte_done = sclk_rise && (bit_cnt == 3'd7) && (state != ST_IDLE);
   assign live_sum = fold_checksum(conv_mode, pin_cfg, ch0_map); // RULE11
   assign temp_pick = (ch0_map[CH_POS_LO +: 5] == TEMP_POS_SEL) && (ch0_map[CH_NEG_LO +: 5] == TEMP_NEG_SEL);

   always_comb
   begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_byte_cnt = byte_cnt;
      next_nbytes = nbytes;
      next_shift_in = shift_in;
      next_shift_out = shift_out;
      next_addr = addr;
      next_is_read = is_read;
      next_wbuf = wbuf;
      next_lrc = lrc;
      next_apply = 1'b0;
      next_conv_mode = conv_mode;
      next_if_mode = if_mode;
      next_pin_cfg = pin_cfg;
      next_ch0_map = ch0_map;
      next_result = result;
      next_channel = channel;
      next_conv_err = conv_err;
      next_rdy_b = rdy_b;
      next_crc_err = crc_err;
      next_reg_err = reg_err;
      next_checksum = checksum;
      next_ref_sum = ref_sum;
      next_dout = dout;
      next_oe = !cs_sync[1];
      pop = 1'b0;

      // a new result lands only while no read of the result register is under way
      if (rdy_b && fifo_valid && !byte_done && !(state == ST_DATA && is_read && addr == ADDR_RESULT))
      begin
         pop = 1'b1;
         next_result = short_word ? round_short(fifo_word.value) : fifo_word.value; // RULE17
         next_channel = fifo_word.channel; // RULE2
         next_conv_err = fifo_word.error;
         next_rdy_b = 1'b0;
      end

      if (sclk_rise && state != ST_IDLE)
      begin
         next_shift_in = byte_val[6:0];
         next_bit_cnt = bit_cnt + 3'd1;
      end

      case (state)
         ST_IDLE:
         begin
            if (cs_fall)
            begin
               next_state = ST_CMD;
               next_bit_cnt = 3'd0;
            end
         end
         ST_CMD:
         begin
            if (byte_done && !byte_val[CMD_WEN_B_BIT]) // RULE7
            begin
               next_addr = byte_val[5:0];
               next_is_read = byte_val[CMD_READ_BIT];
               next_byte_cnt = 3'd0;
               next_lrc = byte_val;
               next_nbytes = reg_bytes(byte_val[5:0], short_word);
               next_state = ST_DATA;
               if (byte_val[CMD_READ_BIT])
               begin
                  case (byte_val[5:0])
                     ADDR_CMD_STATUS: next_shift_out = {status, 24'h00_0000};
                     ADDR_CONV_MODE: next_shift_out = {conv_mode, 16'h0000}; // RULE9
                     ADDR_IF_MODE: next_shift_out = {if_mode, 16'h0000}; // RULE10
                     ADDR_CHECKSUM: next_shift_out = {checksum, 8'h00}; // RULE11
                     ADDR_RESULT:
                     begin
                        if (short_word)
                           next_shift_out = {result[23:8], status, 8'h00}; // RULE1 RULE17
                        else
                           next_shift_out = {result, status}; // RULE1 RULE12
                        next_nbytes = reg_bytes(ADDR_RESULT, short_word) + {2'b00, append}; // RULE1
                        next_rdy_b = 1'b1;
                     end
                     ADDR_PIN_CFG:
                        next_shift_out = {pin_cfg[15:9], err_sync[1], pin_cfg[7:0], 16'h0000}; // RULE13
                     ADDR_IDENTITY: next_shift_out = {IDENTITY_CODE, 16'h0000}; // RULE14
                     ADDR_CH0_MAP: next_shift_out = {ch0_map, 16'h0000}; // RULE15
                     default: next_shift_out = 32'h0000_0000;
                  endcase
                  if (byte_val[5:0] == ADDR_CMD_STATUS)
                     next_crc_err = 1'b0; // RULE16
               end
            end
         end
         ST_DATA:
         begin
            if (byte_done)
            begin
               next_byte_cnt = byte_cnt + 3'd1;
               if (!is_read)
               begin
                  next_wbuf = {wbuf[15:0], byte_val};
                  next_lrc = lrc ^ byte_val;
               end
               if (byte_cnt == nbytes - 3'd1)
               begin
                  next_state = (!is_read && crc_on) ? ST_CHECK : ST_CMD;
                  next_apply = !is_read && !crc_on;
               end
            end
         end
         ST_CHECK:
         begin
            if (byte_done)
            begin
               next_state = ST_CMD;
               next_apply = (byte_val == lrc);
               if (byte_val != lrc)
                  next_crc_err = 1'b1; // RULE16
            end
         end
         default: next_state = ST_IDLE;
      endcase

      if (cs_rise)
         next_state = ST_IDLE;

      // data out: bits change on falling clock, otherwise the pin shows ready, except it holds during a command byte when output hold is set
      if (state == ST_DATA && is_read)
      begin
         if (sclk_fall)
         begin
            next_dout = shift_out[31]; // RULE12
            next_shift_out = {shift_out[30:0], 1'b0};
         end
      end
      else if (!(state == ST_CMD && if_mode[IF_OUT_HOLD_BIT]))
         next_dout = rdy_b;

      // only writable addresses take data; masks keep reserved bits at zero
      if (apply)
      begin
         case (addr)
            ADDR_CONV_MODE: next_conv_mode = wbuf[15:0] & CONV_MODE_MASK; // RULE9 RULE19
            ADDR_IF_MODE: next_if_mode = wbuf[15:0] & IF_MODE_MASK; // RULE10 RULE19
            ADDR_PIN_CFG: next_pin_cfg = wbuf[15:0] & PIN_CFG_MASK; // RULE13 RULE19
            ADDR_CH0_MAP: next_ch0_map = wbuf[15:0] & CH0_MAP_MASK; // RULE15 RULE19
            default: next_conv_mode = conv_mode; // RULE19
         endcase
      end

      // register monitor: reference taken when checking starts, clear by disabling it
      if (if_mode[IF_REG_CHECK_BIT])
      begin
         next_checksum = live_sum; // RULE11
         if (!reg_check_q)
            next_ref_sum = live_sum;
         else if (live_sum != ref_sum)
            next_reg_err = 1'b1;
      end
      else
         next_reg_err = 1'b0;

      if (pin_cfg[PIN_ERR_MODE_LO +: 2] == ERR_MODE_INPUT && !err_sync[1])
         next_conv_err = 1'b1;

      next_buf_on = setup_ain_buf_i | {2{temp_pick && conv_busy_i}}; // RULE6
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state <= ST_IDLE;
         bit_cnt <= 3'd0;
         byte_cnt <= 3'd0;
         nbytes <= 3'd0;
         shift_in <= 7'h00;
         shift_out <= 32'h0000_0000;
         addr <= ADDR_CMD_STATUS;
         is_read <= 1'b0;
         wbuf <= 24'h00_0000;
         lrc <= 8'h00;
         apply <= 1'b0;
         conv_mode <= CONV_MODE_RESET;
         if_mode <= IF_MODE_RESET;
         pin_cfg <= PIN_CFG_RESET;
         ch0_map <= CH0_MAP_RESET;
         checksum <= CHECKSUM_RESET;
         ref_sum <= CHECKSUM_RESET;
         result <= RESULT_RESET;
         {rdy_b, conv_err, crc_err, reg_err, channel} <= STATUS_RESET;
         reg_check_q <= 1'b0;
         dout <= 1'b1;
         oe <= 1'b0;
         buf_on <= 2'b00;
         drive_boost_o <= 1'b0;
         power_switch_o <= 1'b0;
         mux_pos_o <= 5'h00;
         mux_neg_o <= 5'h00;
      end
      else
      begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         byte_cnt <= next_byte_cnt;
         nbytes <= next_nbytes;
         shift_in <= next_shift_in;
         shift_out <= next_shift_out;
         addr <= next_addr;
         is_read <= next_is_read;
         wbuf <= next_wbuf;
         lrc <= next_lrc;
         apply <= next_apply;
         conv_mode <= next_conv_mode;
         if_mode <= next_if_mode;
         pin_cfg <= next_pin_cfg;
         ch0_map <= next_ch0_map;
         checksum <= next_checksum;
         ref_sum <= next_ref_sum;
         result <= next_result;
         rdy_b <= next_rdy_b;
         conv_err <= next_conv_err;
         crc_err <= next_crc_err;
         reg_err <= next_reg_err;
         channel <= next_channel;
         reg_check_q <= if_mode[IF_REG_CHECK_BIT];
         dout <= next_dout;
         oe <= next_oe;
         buf_on <= next_buf_on;
         drive_boost_o <= next_if_mode[IF_DRIVE_BOOST_BIT]; // RULE3
         power_switch_o <= next_pin_cfg[PIN_POWER_SWITCH_BIT]; // RULE4
         mux_pos_o <= next_ch0_map[CH_POS_LO +: 5]; // RULE5
         mux_neg_o <= next_ch0_map[CH_NEG_LO +: 5]; // RULE5
      end
   end

   assign dout_rdy_o = dout;
   assign dout_oe_o = oe;
   assign ain_buf_on_o = buf_on;
   assign mode_cfg_o.channel_zero_on = ch0_map[CH_ENABLE_BIT];
   assign mode_cfg_o.setup_choice_zero = ch0_map[CH_SETUP_LO +: 3];
   assign mode_cfg_o.op_mode = conv_mode[MODE_OP_LO +: 3];
   assign mode_cfg_o.clock_source_sel = conv_mode[MODE_CLK_LO +: 2];
   assign mode_cfg_o.single_cycle_settle = conv_mode[MODE_SINGLE_CYC_BIT];
   assign mode_cfg_o.alternate_sync_mode = if_mode[IF_ALTERNATE_SYNC_MODE_BIT];
   assign mode_cfg_o.continuous_read = if_mode[IF_CONT_READ_BIT];
   assign mode_cfg_o.short_word_len = if_mode[IF_SHORT_WORD_BIT];

endmodule // adc_register_map

// ---- hdl/adc_regs_pkg.sv ----
/*
   Constants, types and helper functions shared by the converter register map, its checker and its bench.
   Assumes a single master clock domain; serial pins are synchronised inside the register map.
*/
package adc_regs_pkg;

   localparam logic [5:0] ADDR_CMD_STATUS = 6'h00;
   localparam logic [5:0] ADDR_CONV_MODE = 6'h01;
   localparam logic [5:0] ADDR_IF_MODE = 6'h02;
   localparam logic [5:0] ADDR_CHECKSUM = 6'h03;
   localparam logic [5:0] ADDR_RESULT = 6'h04;
   localparam logic [5:0] ADDR_PIN_CFG = 6'h06;
   localparam logic [5:0] ADDR_IDENTITY = 6'h07;
   localparam logic [5:0] ADDR_CH0_MAP = 6'h10;

   localparam logic [7:0] STATUS_RESET = 8'h80;
   localparam logic [15:0] CONV_MODE_RESET = 16'hA000;
   localparam logic [15:0] IF_MODE_RESET = 16'h0000;
   localparam logic [15:0] PIN_CFG_RESET = 16'h0800;
   localparam logic [15:0] CH0_MAP_RESET = 16'h8001;
   localparam logic [23:0] CHECKSUM_RESET = 24'h00_0000;
   localparam logic [23:0] RESULT_RESET = 24'h00_0000;

   // writable bits; everything else reads as zero, except pin configuration bit 8, which reads the synchronised error pin level
   localparam logic [15:0] CONV_MODE_MASK = 16'hE77C;
   localparam logic [15:0] IF_MODE_MASK = 16'h19ED;
   localparam logic [15:0] PIN_CFG_MASK = 16'h7EFF;
   localparam logic [15:0] CH0_MAP_MASK = 16'hF3FF;

   // arbitrary identity value, low nibble free
   localparam logic [15:0] IDENTITY_CODE = 16'h0A50;

   localparam int CMD_WEN_B_BIT = 7;
   localparam int CMD_READ_BIT = 6;

   localparam int IF_ALTERNATE_SYNC_MODE_BIT = 12;
   localparam int IF_DRIVE_BOOST_BIT = 11;
   localparam int IF_OUT_HOLD_BIT = 8;
   localparam int IF_CONT_READ_BIT = 7;
   localparam int IF_STATUS_APPEND_BIT = 6;
   localparam int IF_REG_CHECK_BIT = 5;
   localparam int IF_CRC_LO = 2;
   localparam int IF_SHORT_WORD_BIT = 0;

   localparam int MODE_SINGLE_CYC_BIT = 13;
   localparam int MODE_OP_LO = 4;
   localparam int MODE_CLK_LO = 2;

   localparam int PIN_POWER_SWITCH_BIT = 14;
   localparam int PIN_ERR_MODE_LO = 9;
   localparam int PIN_ERR_LEVEL_BIT = 8;
   localparam logic [1:0] ERR_MODE_INPUT = 2'b01;

   localparam int CH_ENABLE_BIT = 15;
   localparam int CH_SETUP_LO = 12;
   localparam int CH_POS_LO = 5;
   localparam int CH_NEG_LO = 0;

   localparam logic [4:0] TEMP_POS_SEL = 5'h11;
   localparam logic [4:0] TEMP_NEG_SEL = 5'h12;

   localparam int RESULT_FIFO_DEPTH = 16;

   typedef struct packed {
      logic [23:0] value;
      logic [3:0] channel;
      logic error;
   } conv_word_s;

   typedef struct packed {
      logic channel_zero_on;
      logic [2:0] setup_choice_zero;
      logic [2:0] op_mode;
      logic [1:0] clock_source_sel;
      logic single_cycle_settle;
      logic alternate_sync_mode;
      logic continuous_read;
      logic short_word_len;
   } mode_cfg_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CMD = 2'b01,
      ST_DATA = 2'b11,
      ST_CHECK = 2'b10
   } spi_state_e;

   // bytes transferred for a register, excluding appended status
   function automatic logic [2:0] reg_bytes(input logic [5:0] addr, input logic short_word);
      case (addr)
         ADDR_CMD_STATUS: reg_bytes = 3'd1;
         ADDR_CHECKSUM: reg_bytes = 3'd3;
         ADDR_RESULT: reg_bytes = short_word ? 3'd2 : 3'd3;
         default: reg_bytes = 3'd2;
      endcase
   endfunction

   function automatic logic [23:0] round_short(input logic [23:0] v);
      if (v[7] && (v[23:8] != 16'hFFFF))
         round_short = {v[23:8] + 16'h0001, 8'h00};
      else
         round_short = {v[23:8], 8'h00};
   endfunction

   function automatic logic [23:0] fold_checksum(input logic [15:0] a, input logic [15:0] b,
                                                 input logic [15:0] c);
      fold_checksum = {a ^ b ^ c, a[15:8] ^ b[7:0] ^ c[15:8]};
   endfunction

endpackage

// ---- hdl/result_fifo.sv ----
/*
   Synchronous FIFO for conversion words with valid/ready on both sides.
   Assumes DEPTH is a power of two and both sides run on the master clock.
*/
module result_fifo #(
   parameter int WIDTH = 29,
   parameter int DEPTH = 16
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   always_comb
   begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count;
      if (push && !pop)
         next_count = count + 1'b1;
      else if (pop && !push)
         next_count = count - 1'b1;
   end

   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready_o <= 1'b1;
         out_valid_o <= 1'b0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         in_ready_o <= (next_count != (AW+1)'(DEPTH));
         out_valid_o <= (next_count != '0);
      end
   end

   // storage has no reset; valid gating keeps stale words invisible
   always_ff @(posedge mclk_i)
   begin
      if (push)
         mem[wr_ptr] <= in_data_i;
   end

   assign out_data_o = mem[rd_ptr];

endmodule // result_fifo

// ---- test/adc_regs_properties.sv ----
/*
   Checker on the converter register map ports.
   Assumes one master clock domain and an async active-low reset.
*/
module adc_regs_properties
   import adc_regs_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic cs_b_i,
   input wire logic conv_busy_i,
   input wire logic [1:0] setup_ain_buf_i,
   input wire logic dout_oe_o,
   input wire logic drive_boost_o,
   input wire logic power_switch_o,
   input wire logic [4:0] mux_pos_o,
   input wire logic [4:0] mux_neg_o,
   input wire logic [1:0] ain_buf_on_o,
   input wire mode_cfg_s mode_cfg_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence s_sel_held;
      $fell(cs_b_i) ##1 !cs_b_i [*4];
   endsequence
   sequence s_desel_held;
      $rose(cs_b_i) ##1 cs_b_i [*4];
   endsequence
   // settings move only inside a frame; a stray update outside one is a decode slip
   a_oe_on_select:
      assert property (s_sel_held |-> dout_oe_o) else $error("oe low in frame");
   a_oe_off_idle:
      assert property (s_desel_held |-> !dout_oe_o) else $error("oe high when idle");
   a_temp_forces_buf:
      assert property (mux_pos_o == TEMP_POS_SEL && mux_neg_o == TEMP_NEG_SEL && conv_busy_i
         |=> ain_buf_on_o == 2'b11) else $error("buffers not forced");
   a_buf_follows_setup:
      assert property (!conv_busy_i |=> ain_buf_on_o == $past(setup_ain_buf_i)) else $error("buffer mismatch");
   a_boost_in_frame:
      assert property ($changed(drive_boost_o) |-> !cs_b_i) else $error("boost moved idle");
   a_switch_in_frame:
      assert property ($changed(power_switch_o) |-> !cs_b_i) else $error("switch moved idle");
   a_mux_in_frame:
      assert property ($changed(mux_pos_o) |-> !cs_b_i) else $error("mux moved idle");
   a_mode_in_frame:
      assert property ($changed(mode_cfg_o) |-> !cs_b_i) else $error("mode moved idle");
endmodule // adc_regs_properties

bind adc_register_map adc_regs_properties u_props (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i),
   .conv_busy_i(conv_busy_i), .setup_ain_buf_i(setup_ain_buf_i), .dout_oe_o(dout_oe_o),
   .drive_boost_o(drive_boost_o), .power_switch_o(power_switch_o), .mux_pos_o(mux_pos_o),
   .mux_neg_o(mux_neg_o), .ain_buf_on_o(ain_buf_on_o), .mode_cfg_o(mode_cfg_o));

// ---- test/spi_host.sv ----
/*
   Host model of the serial port, mode 3, MSB first.
   Assumes its tasks are entered at a falling edge of mclk_i.
*/
module spi_host (
   input wire logic mclk_i,
   input wire logic dout_i,
   output logic sclk_o = 1'b1,
   output logic cs_b_o = 1'b1,
   output logic din_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // 5 low, 3 high: 200 ns a bit, and dout is settled 5 cycles after the fall
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         sclk_o = 1'b0;
         din_o = tx[i];
         repeat (5) @(negedge mclk_i);
         rx[i] = dout_i;
         sclk_o = 1'b1;
         repeat (3) @(negedge mclk_i);
      end
   endtask
   task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] wd, output logic [31:0] rd);
      logic [7:0] b;
      rd = '0;
      cs_b_o = 1'b0;
      repeat (3) @(negedge mclk_i);
      xfer(cmd, b);
      for (int j = n - 1; j >= 0; j--)
      begin
         xfer(wd[8*j +: 8], b);
         rd = {rd[23:0], b};
      end
      repeat (8) @(negedge mclk_i);
      cs_b_o = 1'b1;
      din_o = ~din_o; // a released line must not keep its level
      repeat (8) @(negedge mclk_i);
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] v);
      logic [31:0] r;
      frame({2'b00, a}, 2, {16'h0000, v}, r);
   endtask
   task automatic rd(input logic [5:0] a, input int n, output logic [31:0] v);
      frame({2'b01, a}, n, 32'h0000_0000, v);
   endtask
endmodule // spi_host

// ---- test/tb.sv ----
/*
   Bench for the converter register map: registers, pins and result stream.
   Assumes the spi_host model and a 40 MHz master clock.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import adc_regs_pkg::*;
   logic mclk = 0, rst_b = 0, err_b = 0, valid = 0, busy = 0, rdy, dout, oe, boost, psw, sclk, cs_b, din;
   logic [1:0] sbuf = 2'b00, abuf;
   logic [4:0] mpos, mneg;
   logic [31:0] d;
   conv_word_s word = '0;
   int error_cnt = 0, n_compared = 0, cycles = 0;
   always #12.5 mclk = ~mclk;
   adc_register_map u_dut (.mclk_i(mclk), .rst_b_i(rst_b), .sclk_i(sclk), .cs_b_i(cs_b), .din_i(din),
      .error_in_b_i(err_b), .conv_valid_i(valid), .conv_word_i(word), .conv_busy_i(busy),
      .setup_ain_buf_i(sbuf), .conv_ready_o(rdy), .dout_rdy_o(dout), .dout_oe_o(oe), .drive_boost_o(boost),
      .power_switch_o(psw), .mux_pos_o(mpos), .mux_neg_o(mneg), .ain_buf_on_o(abuf), .mode_cfg_o());
   spi_host u_host (.mclk_i(mclk), .dout_i(dout), .sclk_o(sclk), .cs_b_o(cs_b), .din_o(din));
   task automatic final_report();
      if (error_cnt == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", s, e, g);
         error_cnt++;
      end
   endtask
   task automatic rchk(input logic [5:0] a, input int n, input logic [31:0] e);
      u_host.rd(a, n, d);
      chk($sformatf("reg %h", a), e, d);
   endtask
   task automatic push(input logic [23:0] v, input logic [3:0] ch, input logic er);
      @(negedge mclk);
      for (int t = 0; t < 40 && !rdy; t++)
         @(negedge mclk);
      word = '{value: v, channel: ch, error: er};
      valid = 1'b1;
      @(negedge mclk);
      valid = 1'b0;
   endtask
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         error_cnt++;
         final_report();
      end
   end
   initial
   begin
      repeat (10) @(negedge mclk);
      rst_b = 1'b1;
      repeat (4) @(negedge mclk);
      rchk(ADDR_CMD_STATUS, 1, 32'h0000_0080);
      rchk(ADDR_CONV_MODE, 2, 32'h0000_A000);
      rchk(ADDR_IF_MODE, 2, 32'h0000_0000);
      rchk(ADDR_CHECKSUM, 3, 32'h0000_0000);
      rchk(ADDR_RESULT, 3, 32'h0000_0000);
      rchk(ADDR_PIN_CFG, 2, 32'h0000_0800);
      rchk(ADDR_CH0_MAP, 2, 32'h0000_8001);
      rchk(6'h05, 2, 32'h0000_0000);
      u_host.wr(ADDR_IDENTITY, 16'h0000);
      u_host.rd(ADDR_IDENTITY, 2, d);
      chk("identity", {16'h0000, IDENTITY_CODE[15:4], 4'h0}, {d[31:4], 4'h0});
      u_host.wr(ADDR_CONV_MODE, 16'hFFFF);
      rchk(ADDR_CONV_MODE, 2, {16'h0000, CONV_MODE_MASK});
      u_host.wr(ADDR_CH0_MAP, 16'hFFFF);
      rchk(ADDR_CH0_MAP, 2, {16'h0000, CH0_MAP_MASK});
      chk("mux", 32'h0000_03FF, {22'h0, mpos, mneg});
      u_host.wr(ADDR_CH0_MAP, {6'b100000, TEMP_POS_SEL, TEMP_NEG_SEL});
      busy = 1'b1;
      repeat (3) @(negedge mclk);
      chk("forced", 32'h0000_0003, {30'h0, abuf});
      busy = 1'b0;
      sbuf = 2'b10;
      repeat (3) @(negedge mclk);
      chk("buffers", 32'h0000_0002, {30'h0, abuf});
      u_host.wr(ADDR_PIN_CFG, 16'h4000);
      chk("switch on", 32'h0000_0001, {31'h0, psw});
      u_host.wr(ADDR_PIN_CFG, 16'h0000);
      err_b = 1'b1;
      chk("switch off", 32'h0000_0000, {31'h0, psw});
      rchk(ADDR_PIN_CFG, 2, 32'h0000_0100);
      u_host.wr(ADDR_IF_MODE, 16'h0004);
      u_host.frame(8'h01, 3, 32'h0000_00FF, d);
      rchk(ADDR_CONV_MODE, 2, {16'h0000, CONV_MODE_MASK});
      rchk(ADDR_CMD_STATUS, 1, 32'h0000_00A0);
      rchk(ADDR_CMD_STATUS, 1, 32'h0000_0080);
      u_host.frame(8'h01, 3, 32'h0020_0021, d);
      rchk(ADDR_CONV_MODE, 2, 32'h0000_2000);
      u_host.frame(8'h02, 3, 32'h0008_606A, d);
      rchk(ADDR_CHECKSUM, 3, 32'h00A2_32A2);
      chk("boost", 32'h0000_0001, {31'h0, boost});
      // one word sits in the result register, so 17 fit before refusal
      for (int k = 0; k < 17; k++)
         push(24'hA5_0000 + 24'(k), k[3:0], k[0]);
      repeat (4) @(negedge mclk);
      chk("full", 32'h0000_0000, {31'h0, rdy});
      for (int k = 0; k < 17; k++)
      begin
         u_host.rd(ADDR_RESULT, 4, d);
         chk("result", 32'h00A5_0000 + k, {8'h00, d[31:8]});
         chk("status", {25'h0, k[0], 2'b00, k[3:0]}, {25'h0, d[6:0]});
      end
      chk("drained", 32'h0000_0001, {31'h0, rdy});
      u_host.wr(ADDR_IF_MODE, 16'h0841);
      push(24'h12_3480, 4'h5, 1'b0);
      repeat (8) @(negedge mclk);
      u_host.rd(ADDR_RESULT, 3, d);
      chk("short", 32'h0012_3505, {8'h00, d[23:8], 1'b0, d[6:0]});
      final_report();
   end
endmodule // tb
